//--- src/svr_consts.svh
// Function
// - missed strobe within timeout asserts reset
// - watchdog timeout nominally 1.6 seconds
// - manual reset input active asserts reset
// - reset held 200 ms after cause ends
// - power-up holds reset until supply good
// - watchdog and manual inputs are build options
// - active-low, active-high or both outputs
// - watchdog restarts on edge or reset
// - manual low 1 us counts, glitches rejected
// - supply low asserts reset
`ifndef SVR_CONSTS_SVH
`define SVR_CONSTS_SVH
`define SVR_CLK_PERIOD_NS 10
`define SVR_WDOG_TIMEOUT_MS 1600
`define SVR_WDOG_CYCLES ((`SVR_WDOG_TIMEOUT_MS * 1000000) / `SVR_CLK_PERIOD_NS)
`define SVR_RST_TIMEOUT_MS 200
`define SVR_RST_CYCLES ((`SVR_RST_TIMEOUT_MS * 1000000) / `SVR_CLK_PERIOD_NS)
`define SVR_MR_MIN_NS 1000
`define SVR_MR_CYCLES ((`SVR_MR_MIN_NS + `SVR_CLK_PERIOD_NS - 1) / `SVR_CLK_PERIOD_NS)
`define SVR_CNT_W 28
`define SVR_SYNC_RST 3'h6
`define SVR_SUP_RST 1'h1
`define SVR_ASSERT_RST 1'h1
`endif

//--- src/svr_pkg.sv
package svr_pkg;
	typedef logic [27:0] svr_cnt_t;
	typedef struct packed {
		logic supply_low;
		logic manual_reset_n;
		logic watchdog_strobe_in;
	} svr_in_s;
	typedef struct packed {
		logic reset_n;
		logic reset;
	} svr_out_s;
endpackage

//--- src/svr_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
`include "svr_consts.svh"
module svr_supervisor #(
	parameter bit          HAS_WDOG    = 1'b1,
	parameter bit          HAS_MR      = 1'b1,
	parameter bit          HAS_RST_LOW = 1'b1,
	parameter bit          HAS_RST_HI  = 1'b1,
	parameter int unsigned WDOG_CYCLES = `SVR_WDOG_CYCLES,
	parameter int unsigned RST_CYCLES  = `SVR_RST_CYCLES
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire svr_pkg::svr_in_s  pins,
	output var  svr_pkg::svr_out_s rst_out
);
	import svr_pkg::*;

	// a variant with neither input could raise reset only on a low supply after power-up,
	// so the watchdog stays in when both are switched off
	localparam bit USE_WDOG = HAS_WDOG || !HAS_MR;
	localparam bit USE_MR   = HAS_MR;

	// 28 bits cover the longest count, the watchdog period at 100 MHz
	localparam svr_cnt_t MR_CYC  = svr_cnt_t'(`SVR_MR_CYCLES);
	localparam svr_cnt_t WD_CYC  = svr_cnt_t'(WDOG_CYCLES);
	localparam svr_cnt_t RST_CYC = svr_cnt_t'(RST_CYCLES);
	localparam svr_cnt_t CNT_ONE = svr_cnt_t'(1);

	// bit positions of the pins inside the packed input struct
	localparam int         SYN_SUP = 2;
	localparam int         SYN_MR  = 1;
	localparam int         SYN_WDI = 0;
	localparam logic [2:0] SYN_RST = `SVR_SYNC_RST;

	logic [2:0] pin_vec;
	logic [2:0] chain_q [3];
	logic [2:0] agree_d;
	logic [2:0] level_d;
	logic       sup_q;
	logic       mr_high_d;
	logic       mr_low_lvl_d;
	logic       mr_done_d;
	logic       mr_low_q;
	logic       wdi_q;
	logic       wdi_change_d;
	logic       wdi_edge_q;
	logic       wd_done_d;
	logic       wd_fire_q;
	logic       sup_cause_d;
	logic       mr_cause_d;
	logic       wd_cause_d;
	logic       cause_d;
	logic       hold_done_d;
	logic       asserted_q;
	logic       low_d;
	logic       high_d;
	svr_cnt_t   mr_cnt_q;
	svr_cnt_t   wd_cnt_q;
	svr_cnt_t   hold_cnt_q;

	assign pin_vec = pins;

	// three flops per pin; stage 1 is read by stage 2 only, so a
	// metastable first stage never reaches the decision logic
	for (genvar g = 0; g < 3; g++) begin : g_sync
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				chain_q[g] <= {3{SYN_RST[g]}};
			end else begin
				chain_q[g] <= {chain_q[g][1:0], pin_vec[g]};
			end
		end

		// a level counts only once stages 2 and 3 agree
		assign agree_d[g] = chain_q[g][2] == chain_q[g][1];
		assign level_d[g] = chain_q[g][2];
	end

	// supply level; starts low-true so power-up always holds reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sup_q <= `SVR_SUP_RST;
		end else if (agree_d[SYN_SUP]) begin
			sup_q <= level_d[SYN_SUP];
		end
	end

	// settled strobe level, the reference for edge detection; its reset
	// value matches the chain so no false edge follows reset
	assign wdi_change_d = agree_d[SYN_WDI] && (level_d[SYN_WDI] != wdi_q);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wdi_q <= SYN_RST[SYN_WDI];
		end else if (agree_d[SYN_WDI]) begin
			wdi_q <= level_d[SYN_WDI];
		end
	end

	// one-cycle pulse on either edge; rise and fall count alike
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wdi_edge_q <= 1'b0;
		end else if (wdi_change_d) begin
			wdi_edge_q <= USE_WDOG;
		end else begin
			wdi_edge_q <= 1'b0;
		end
	end

	// manual filter: low must persist 1 us before it counts
	assign mr_high_d    = agree_d[SYN_MR] && level_d[SYN_MR];
	assign mr_low_lvl_d = agree_d[SYN_MR] && !level_d[SYN_MR];
	assign mr_done_d    = mr_cnt_q >= MR_CYC - CNT_ONE;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mr_cnt_q <= '0;
		end else if (!USE_MR || mr_high_d) begin
			mr_cnt_q <= '0;
		end else if (mr_low_lvl_d && !mr_done_d) begin
			mr_cnt_q <= mr_cnt_q + CNT_ONE;
		end
	end

	// short lows only restart the count, so glitches never reach reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mr_low_q <= 1'b0;
		end else if (!USE_MR || mr_high_d) begin
			mr_low_q <= 1'b0;
		end else if (mr_low_lvl_d && mr_done_d) begin
			mr_low_q <= 1'b1;
		end
	end

	// watchdog restarts on a strobe edge and while reset is out;
	// a strobe seen during reset is lost, the count restarts anyway
	assign wd_done_d = wd_cnt_q >= WD_CYC - CNT_ONE;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wd_cnt_q <= '0;
		end else if (!USE_WDOG || asserted_q || wdi_edge_q) begin
			wd_cnt_q <= '0;
		end else if (!wd_done_d) begin
			wd_cnt_q <= wd_cnt_q + CNT_ONE;
		end
	end

	// expiry stays up until the reset it caused is out
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wd_fire_q <= 1'b0;
		end else if (!USE_WDOG || asserted_q || wdi_edge_q) begin
			wd_fire_q <= 1'b0;
		end else if (wd_done_d) begin
			wd_fire_q <= 1'b1;
		end
	end

	// each cause on its own, so a waveform shows which one holds reset
	always_comb begin
		sup_cause_d = sup_q;
		mr_cause_d  = mr_low_q && USE_MR;
		wd_cause_d  = wd_fire_q && USE_WDOG;
		cause_d     = sup_cause_d || mr_cause_d || wd_cause_d;
	end

	// any cause present reloads the hold timer
	assign hold_done_d = hold_cnt_q >= RST_CYC - CNT_ONE;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hold_cnt_q <= '0;
		end else if (cause_d) begin
			hold_cnt_q <= '0;
		end else if (asserted_q && !hold_done_d) begin
			hold_cnt_q <= hold_cnt_q + CNT_ONE;
		end
	end

	// reset level; a new cause during the hold starts the hold again
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			asserted_q <= `SVR_ASSERT_RST;
		end else if (cause_d) begin
			asserted_q <= 1'b1;
		end else if (asserted_q && hold_done_d) begin
			asserted_q <= 1'b0;
		end
	end

	// an absent output stage parks at its inactive level
	always_comb begin
		low_d  = 1'b1;
		high_d = 1'b0;
		if (HAS_RST_LOW) begin
			low_d = ~asserted_q;
		end
		if (HAS_RST_HI) begin
			high_d = asserted_q;
		end
	end

	// both stages from flops, so the host never sees a decode glitch
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rst_out.reset_n <= ~HAS_RST_LOW;
			rst_out.reset   <= HAS_RST_HI;
		end else begin
			rst_out.reset_n <= low_d;
			rst_out.reset   <= high_d;
		end
	end
endmodule
`default_nettype wire

//--- test/svr_host.sv
`timescale 1ns/1ps
`default_nettype none
module svr_host (input wire logic clk, run, output var logic stb);
	initial stb = 1'h0;
	always @(posedge clk)
		if (run && $time % 400 == 5) stb <= ~stb;
endmodule
`default_nettype wire

//--- test/svr_properties.sv
`timescale 1ns/1ps
`default_nettype none
module svr_props import svr_pkg::*; #(int RST_CYCLES=50, WDOG_CYCLES=200) (
	input wire logic     clk,
	input wire logic     rst_n,
	input wire svr_in_s  pins,
	input wire svr_out_s rst_out
);
	int c_q, m_q, w_q;
	// w_q sees edges before the input synchronizer does, so it reads high
	always_ff @(posedge clk) begin
		c_q <= pins.supply_low | !pins.manual_reset_n ? 0 : c_q + 1;
		m_q <= pins.manual_reset_n ? 0 : m_q + 1;
		w_q <= $changed(pins.watchdog_strobe_in) | !rst_out.reset_n ? 0 : w_q + 1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_low8; pins.supply_low [*8]; endsequence
	a_out_pair: assert property (
		rst_out.reset != rst_out.reset_n) else $error("pair");
	a_power_hold: assert property (
		$rose(rst_n) |-> !rst_out.reset_n) else $error("power");
	a_supply_low: assert property (
		s_low8 |-> !rst_out.reset_n) else $error("supply");
	a_hold_min: assert property (
		$rose(rst_out.reset_n) |-> c_q >= RST_CYCLES) else $error("short");
	a_release_by: assert property (
		c_q == RST_CYCLES + 20 |-> rst_out.reset_n) else $error("late");
	a_manual_in: assert property (
		m_q == 110 |-> !rst_out.reset_n) else $error("manual");
	a_no_stray: assert property (
		$fell(rst_out.reset_n) && c_q > 0 |-> w_q >= WDOG_CYCLES - 5)
		else $error("stray");
	a_wdog_fire: assert property (
		w_q == WDOG_CYCLES + 10 |-> !rst_out.reset_n) else $error("wdog");
endmodule
bind svr_supervisor svr_props #(
	.RST_CYCLES(RST_CYCLES), .WDOG_CYCLES(WDOG_CYCLES)) u_svr_props (
	.clk(clk), .rst_n(rst_n), .pins(pins), .rst_out(rst_out));
`default_nettype wire

//--- test/svr_supervisor_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module svr_supervisor_tb_top;
	import svr_pkg::*;
	logic clk = 1'h0, rst_n = 1'h0, sup = 1'h0, mr_n = 1'h1, run = 1'h1, stb;
	svr_out_s rst_out;
	int fails, comparisons;
	always #5 clk = ~clk;
	svr_host u_svr_host (.clk(clk), .run(run), .stb(stb));
	svr_supervisor #(.WDOG_CYCLES(200), .RST_CYCLES(50)) u_svr_supervisor (
		.clk(clk), .rst_n(rst_n), .pins({sup, mr_n, stb}), .rst_out(rst_out));
	task automatic chk(string s, logic a, int n, bit u = 0);
		repeat (n) if (!u || rst_out.reset_n !== !a) @(negedge clk);
		comparisons++;
		if (rst_out !== {!a, a}) begin
			fails++;
			$display("wrong value %s expected %b seen %b", s, a, rst_out.reset);
			if (u) close_out;
		end
	endtask
	task automatic close_out;
		$display("fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic t_inputs;
		@(posedge clk) sup <= 1'h1;
		chk("supply low", 1'h1, 10);
		@(posedge clk) sup <= 1'h0;
		chk("supply hold", 1'h1, 45);
		chk("supply release", 1'h0, 30, 1);
		@(posedge clk) mr_n <= 1'h0;
		repeat (5) @(posedge clk);
		mr_n <= 1'h1;
		chk("manual glitch", 1'h0, 30);
		@(posedge clk) mr_n <= 1'h0;
		chk("manual low", 1'h1, 115);
		@(posedge clk) mr_n <= 1'h1;
		chk("manual release", 1'h0, 70, 1);
		$display("t_inputs done");
	endtask
	task automatic t_wdog;
		@(posedge clk) run <= 1'h0;
		chk("quiet host early", 1'h0, 120);
		chk("quiet host", 1'h1, 150, 1);
		@(posedge clk) run <= 1'h1;
		chk("after watchdog", 1'h0, 100, 1);
		chk("strobing host", 1'h0, 250);
		$display("t_wdog done");
	endtask
	task automatic t_power;
		repeat (6) @(posedge clk);
		rst_n <= 1'h1;
		chk("power up", 1'h1, 1);
		chk("power release", 1'h0, 80, 1);
		$display("t_power done");
	endtask
	initial begin
		t_power;
		t_inputs;
		t_wdog;
		close_out;
	end
endmodule
`default_nettype wire
